// ---- hw/agtc_pkg.sv ----
/*
 * Constants for the left-channel AGC time constant configuration block.
 * Assumes an 8-bit control register port with 7-bit register numbers.
 */
package agtc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [6:0] ATTACK_ADDR = 7'h67;
    localparam logic [6:0] DECAY_ADDR = 7'h68;
    localparam logic [7:0] ATTACK_RESET = 8'h00;
    localparam logic [7:0] DECAY_RESET = 8'h00;

    // ------------------------------------------------------------------
    // field positions, shared by both registers
    // ------------------------------------------------------------------
    localparam int SEL_BIT = 7;
    localparam int BASE_HI = 6;
    localparam int BASE_LO = 5;
    localparam int MULT_HI = 4;
    localparam int MULT_LO = 2;

    // ------------------------------------------------------------------
    // baseline times in milliseconds
    // ------------------------------------------------------------------
    localparam logic [15:0] ATTACK_MS_0 = 16'h0007;
    localparam logic [15:0] ATTACK_MS_1 = 16'h0008;
    localparam logic [15:0] ATTACK_MS_2 = 16'h000A;
    localparam logic [15:0] ATTACK_MS_3 = 16'h000B;
    localparam logic [15:0] DECAY_MS_0 = 16'h0032;
    localparam logic [15:0] DECAY_MS_1 = 16'h0096;
    localparam logic [15:0] DECAY_MS_2 = 16'h00FA;
    localparam logic [15:0] DECAY_MS_3 = 16'h015E;

    // ------------------------------------------------------------------
    // decay caps in milliseconds; the ratio arrives as twice its value
    // ------------------------------------------------------------------
    localparam logic [15:0] CAP_MS_R1 = 16'h0FA0;   // 4 s
    localparam logic [15:0] CAP_MS_R1P5 = 16'h15E0; // 5.6 s
    localparam logic [15:0] CAP_MS_R2 = 16'h1F40;   // 8 s
    localparam logic [15:0] CAP_MS_R2P5 = 16'h2580; // 9.6 s
    localparam logic [15:0] CAP_MS_R3 = 16'h2BC0;   // 11.2 s
    localparam logic [15:0] CAP_MS_R4 = 16'h3E80;   // 16 s
    localparam logic [15:0] CAP_MS_R5 = 16'h4B00;   // 19.2 s
    localparam logic [15:0] CAP_MS_R5P5 = 16'h5780; // 22.4 s

endpackage

// ---- hw/agtc_config.sv ----
/*
 * Left AGC attack and decay time configuration: two control registers,
 * source selection against the older AGC setting, baseline times scaled
 * by a power of two, and a decay cap set by the ADC rate divider ratio.
 * Assumes the codec's control bus front end presents single-cycle
 * register read and write strobes synchronous to ref_clk.
 */
// Behaviour
// - attack register top bit picks legacy register 26 time or this register's fields
// - attack baseline codes 00..11 give 7, 8, 10, 11 ms
// - attack multiplier code n scales baseline by two to the n
// - decay register top bit picks legacy register 26 time or this register's fields
// - decay baseline codes 00..11 give 50, 150, 250, 350 ms
// - decay multiplier code n scales baseline by two to the n
// - decay capped 4 to 19.2 s for divider ratios 1 to 5
// - decay capped at 22.4 s for divider ratios 5.5 and 6
`timescale 1ns/10ps
module agtc_config #(
    parameter int TIME_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [TIME_W-1:0] legacy_attack_ms,
    input wire logic [TIME_W-1:0] legacy_decay_ms,
    input wire logic [3:0] adc_rate_divider_ratio,
    output logic [TIME_W-1:0] attack_ms,
    output logic [TIME_W-1:0] decay_ms,
    output logic attack_from_reg,
    output logic decay_from_reg
);

    // elaboration check: lookups, shifts and caps are all sized for 16-bit milliseconds
    if (TIME_W != 16) begin : g_time_w_check
        $error("agtc_config: TIME_W must be 16 to hold 44800 ms");
    end

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] attack_reg;
    logic [7:0] decay_reg;

    wire hit_attack = (reg_addr == agtc_pkg::ATTACK_ADDR);
    wire hit_decay = (reg_addr == agtc_pkg::DECAY_ADDR);

    // reserved bits are stored as written; keeping them zero is software's job
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            attack_reg <= agtc_pkg::ATTACK_RESET;
            decay_reg <= agtc_pkg::DECAY_RESET;
        end else begin
            if (reg_wr && hit_attack) begin
                attack_reg <= reg_wdata;
            end
            if (reg_wr && hit_decay) begin
                decay_reg <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // read port: data one cycle after the strobe, unmapped reads as zero
    // ------------------------------------------------------------------
    wire [7:0] next_rdata = hit_attack ? attack_reg : (hit_decay ? decay_reg : 8'h00);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    wire att_sel = attack_reg[agtc_pkg::SEL_BIT];
    wire [1:0] att_base = attack_reg[agtc_pkg::BASE_HI:agtc_pkg::BASE_LO];
    wire [2:0] att_mult = attack_reg[agtc_pkg::MULT_HI:agtc_pkg::MULT_LO];
    wire dec_sel = decay_reg[agtc_pkg::SEL_BIT];
    wire [1:0] dec_base = decay_reg[agtc_pkg::BASE_HI:agtc_pkg::BASE_LO];
    wire [2:0] dec_mult = decay_reg[agtc_pkg::MULT_HI:agtc_pkg::MULT_LO];

    // baseline lookups
    wire [15:0] att_base_ms = (att_base == 2'd0) ? agtc_pkg::ATTACK_MS_0 :
                              (att_base == 2'd1) ? agtc_pkg::ATTACK_MS_1 :
                              (att_base == 2'd2) ? agtc_pkg::ATTACK_MS_2 :
                              agtc_pkg::ATTACK_MS_3;
    wire [15:0] dec_base_ms = (dec_base == 2'd0) ? agtc_pkg::DECAY_MS_0 :
                              (dec_base == 2'd1) ? agtc_pkg::DECAY_MS_1 :
                              (dec_base == 2'd2) ? agtc_pkg::DECAY_MS_2 :
                              agtc_pkg::DECAY_MS_3;

    // a left shift is the power-of-two factor; 350 ms x 128 still fits 16 bits
    wire [15:0] att_prog_ms = att_base_ms << att_mult;
    wire [15:0] dec_prog_ms = dec_base_ms << dec_mult;

    // source selection
    wire [15:0] att_pick = att_sel ? att_prog_ms : legacy_attack_ms;
    wire [15:0] dec_pick = dec_sel ? dec_prog_ms : legacy_decay_ms;

    // ------------------------------------------------------------------
    // decay cap from the divider ratio (input carries twice the ratio);
    // codes outside 2..12 fall back to the loosest cap
    // ------------------------------------------------------------------
    wire [3:0] r2 = adc_rate_divider_ratio;
    wire [15:0] cap_ms = (r2 == 4'd2) ? agtc_pkg::CAP_MS_R1 :
                         (r2 == 4'd3) ? agtc_pkg::CAP_MS_R1P5 :
                         (r2 == 4'd4) ? agtc_pkg::CAP_MS_R2 :
                         (r2 == 4'd5) ? agtc_pkg::CAP_MS_R2P5 :
                         (r2 == 4'd6 || r2 == 4'd7) ? agtc_pkg::CAP_MS_R3 :
                         (r2 == 4'd8 || r2 == 4'd9) ? agtc_pkg::CAP_MS_R4 :
                         (r2 == 4'd10) ? agtc_pkg::CAP_MS_R5 :
                         agtc_pkg::CAP_MS_R5P5;
    // the cap also bounds the legacy source, since the limit is on the AGC itself
    wire [15:0] dec_capped = (dec_pick > cap_ms) ? cap_ms : dec_pick;

    // ------------------------------------------------------------------
    // outputs: recomputed every cycle, so a write shows one edge later
    // with no AGC reset needed
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            attack_ms <= 16'h0000;
            decay_ms <= 16'h0000;
            attack_from_reg <= 1'b0;
            decay_from_reg <= 1'b0;
        end else begin
            attack_ms <= att_pick;
            decay_ms <= dec_capped;
            attack_from_reg <= att_sel;
            decay_from_reg <= dec_sel;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_attack_legacy_path: assert property (
        @(posedge ref_clk) disable iff (rst)
        !att_sel |=> attack_ms == $past(legacy_attack_ms))
        else $error("attack time not taken from legacy setting");

    a_attack_base_min: assert property (
        @(posedge ref_clk) disable iff (rst)
        (att_sel && att_base == 2'd0 && att_mult == 3'd0) |=> attack_ms == 16'h0007)
        else $error("attack baseline code 00 is not 7 ms");

    a_attack_scaled_max: assert property (
        @(posedge ref_clk) disable iff (rst)
        (att_sel && att_base == 2'd3 && att_mult == 3'd7) |=> attack_ms == 16'h0580)
        else $error("attack 11 ms x 128 is not 1408 ms");

    a_decay_legacy_path: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!dec_sel && legacy_decay_ms <= cap_ms) |=> decay_ms == $past(legacy_decay_ms))
        else $error("decay time not taken from legacy setting");

    a_decay_base_step: assert property (
        @(posedge ref_clk) disable iff (rst)
        (dec_sel && dec_base == 2'd1 && dec_mult == 3'd0) |=> decay_ms == 16'h0096)
        else $error("decay baseline code 01 is not 150 ms");

    a_decay_scaled_x8: assert property (
        @(posedge ref_clk) disable iff (rst)
        (dec_sel && dec_base == 2'd0 && dec_mult == 3'd3) |=> decay_ms == 16'h0190)
        else $error("decay 50 ms x 8 is not 400 ms");

    a_decay_cap_ratio1: assert property (
        @(posedge ref_clk) disable iff (rst)
        (r2 == 4'd2) |=> decay_ms <= 16'h0FA0)
        else $error("decay above 4 s at ratio 1");

    a_decay_cap_ratio6: assert property (
        @(posedge ref_clk) disable iff (rst)
        (r2 == 4'd12 && dec_sel && dec_base == 2'd3 && dec_mult == 3'd7)
        |=> decay_ms == 16'h5780)
        else $error("decay not capped at 22.4 s at ratio 6");

    a_write_takes_effect: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && hit_attack) |-> ##2 attack_from_reg == $past(reg_wdata[7], 2))
        else $error("attack source write not applied two edges later");

    a_attack_base_step: assert property (
        @(posedge ref_clk) disable iff (rst)
        (att_sel && att_base == 2'd2 && att_mult == 3'd0) |=> attack_ms == 16'h000A)
        else $error("attack baseline code 10 is not 10 ms");

    a_attack_scaled_x16: assert property (
        @(posedge ref_clk) disable iff (rst)
        (att_sel && att_base == 2'd1 && att_mult == 3'd4) |=> attack_ms == 16'h0080)
        else $error("attack 8 ms x 16 is not 128 ms");

    a_decay_cap_ratio2p5: assert property (
        @(posedge ref_clk) disable iff (rst)
        (r2 == 4'd5) |=> decay_ms <= 16'h2580)
        else $error("decay above 9.6 s at ratio 2.5");

    a_decay_cap_ratio5: assert property (
        @(posedge ref_clk) disable iff (rst)
        (r2 == 4'd10 && dec_sel && dec_base == 2'd3 && dec_mult == 3'd7)
        |=> decay_ms == 16'h4B00)
        else $error("decay not capped at 19.2 s at ratio 5");

    a_decay_cap_ratio5p5: assert property (
        @(posedge ref_clk) disable iff (rst)
        (r2 == 4'd11 && dec_sel && dec_base == 2'd3 && dec_mult == 3'd7)
        |=> decay_ms == 16'h5780)
        else $error("decay not capped at 22.4 s at ratio 5.5");

    a_decay_write_effect: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && hit_decay) |-> ##2 decay_from_reg == $past(reg_wdata[7], 2))
        else $error("decay source write not applied two edges later");

endmodule

// ---- sim/tb_agtc_config.sv ----
/*
 * Self-checking bench for the left AGC attack/decay time configuration block.
 * Assumes single-cycle register strobes and a one-cycle output latency.
 */
`timescale 1ns/10ps
module tb_agtc_config;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [15:0] legacy_attack_ms = 16'h0123;
    logic [15:0] legacy_decay_ms = 16'h0456;
    logic [3:0] adc_rate_divider_ratio = 4'hC;
    logic [15:0] attack_ms;
    logic [15:0] decay_ms;
    logic attack_from_reg;
    logic decay_from_reg;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] atk_base [4] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B};
    logic [15:0] dcy_base [4] = '{16'h0032, 16'h0096, 16'h00FA, 16'h015E};
    logic [15:0] cap_tab [16] = '{16'h5780, 16'h5780, 16'h0FA0, 16'h15E0, 16'h1F40, 16'h2580,
        16'h2BC0, 16'h2BC0, 16'h3E80, 16'h3E80, 16'h4B00, 16'h5780, 16'h5780, 16'h5780,
        16'h5780, 16'h5780};

    agtc_config agtc_config_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .legacy_attack_ms(legacy_attack_ms),
        .legacy_decay_ms(legacy_decay_ms), .adc_rate_divider_ratio(adc_rate_divider_ratio),
        .attack_ms(attack_ms), .decay_ms(decay_ms), .attack_from_reg(attack_from_reg),
        .decay_from_reg(decay_from_reg));

    // ------------------------------------------------------------------
    // clock, checking and bus helpers
    // ------------------------------------------------------------------
    // free-running 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write then let the outputs take one more edge to follow the register
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // read data stands for one cycle only, so look right after the answering edge
        #1;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset contents, unmapped read and the legacy path out of reset
    task automatic t_reset;
        rd(7'h67, 8'h00);
        rd(7'h68, 8'h00);
        rd(7'h69, 8'h00);
        @(posedge ref_clk);
        #1;
        chk({15'h0000, reg_rvalid}, 16'h0000);
        chk(attack_ms, legacy_attack_ms);
        chk(decay_ms, legacy_decay_ms);
    endtask

    // every attack baseline and multiplier, then back to the legacy source
    task automatic t_attack;
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m++) begin
                wr(7'h67, {1'b1, b[1:0], m[2:0], 2'b00});
                chk(attack_ms, atk_base[b] << m);
                chk({15'h0000, attack_from_reg}, 16'h0001);
            end
        end
        rd(7'h67, 8'hFC);
        wr(7'h67, 8'h7C);
        chk(attack_ms, legacy_attack_ms);
        chk({15'h0000, attack_from_reg}, 16'h0000);
    endtask

    // every decay baseline and multiplier under the widest cap
    task automatic t_decay;
        logic [15:0] e;
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 8; m++) begin
                wr(7'h68, {1'b1, b[1:0], m[2:0], 2'b00});
                e = dcy_base[b] << m;
                chk(decay_ms, (e > 16'h5780) ? 16'h5780 : e);
                chk({15'h0000, decay_from_reg}, 16'h0001);
            end
        end
        wr(7'h68, 8'h7C);
        chk(decay_ms, legacy_decay_ms);
    endtask

    // longest decay against every divider ratio code
    task automatic t_cap;
        wr(7'h68, 8'hFC);
        for (int r = 0; r < 16; r++) begin
            @(posedge ref_clk);
            adc_rate_divider_ratio <= r[3:0];
            repeat (2) @(posedge ref_clk);
            #1;
            chk(decay_ms, cap_tab[r]);
        end
        rd(7'h68, 8'hFC);
        // the cap bounds the legacy source as well
        wr(7'h68, 8'h7C);
        @(posedge ref_clk);
        adc_rate_divider_ratio <= 4'h2;
        legacy_decay_ms <= 16'h2710;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(decay_ms, 16'h0FA0);
    endtask

    // reset in mid-run clears the attack register and returns attack to the legacy source
    task automatic t_rerun;
        wr(7'h67, 8'hE0);
        chk(attack_ms, 16'h000B);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(attack_ms, 16'h0000);
        @(posedge ref_clk);
        rst <= 1'b0;
        rd(7'h67, 8'h00);
        chk(attack_ms, legacy_attack_ms);
        chk({15'h0000, attack_from_reg}, 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hang costs a mismatch; the tests need well under 20k cycles
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_attack();
        t_decay();
        t_cap();
        t_rerun();
        report_and_stop();
    end
endmodule
